// [hw/etcs_channel.v]
// one eight-bit timer channel with its clock select, flags and output control
//
// Added by the designer: the register addresses and the AHB-Lite register port.
`default_nettype none
`include "etcs_map.vh"

module etcs_channel #(
    parameter CHANNEL = 0,
    parameter PRESC_W = 11
) (
    // system
    input wire hclk,
    input wire hresetn,
    // ahb-lite slave
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output wire hreadyout,
    output wire hresp,
    output reg [31:0] hrdata,
    // power management
    input wire standby_req,
    // timer pins
    input wire external_count_input,
    output wire timer_output_pin,
    output wire timer_output_en,
    // interrupt request lines
    output wire irq_compare_a,
    output wire irq_compare_b,
    output wire irq_wrap
);

    // ****************************************
    // bus slave
    // ****************************************

    localparam ST_IDLE = 3'b001;
    localparam ST_RDW = 3'b010;
    localparam ST_RDD = 3'b100;

    reg [2:0] bus_st;
    reg [2:0] next_bus_st;
    reg [7:0] dp_addr;
    reg wr_act;
    reg [7:0] next_rdata;

    reg [7:0] timer_control_reg;
    reg [2:0] flag;
    reg [2:0] armed;
    reg [3:0] out_sel;
    reg [7:0] time_constant_a;
    reg [7:0] time_constant_b;
    reg [7:0] count_value;
    reg prescale_range;
    reg [PRESC_W-1:0] presc;
    reg tap_q;
    reg out_level;

    wire addr_ok;
    wire wr_ctrl;
    wire wr_flags;
    wire wr_tca;
    wire wr_tcb;
    wire wr_count;
    wire wr_range;
    wire rd_flags;
    wire [7:0] wbyte;
    wire [7:0] flags_view;

    // only whole-word transfers are taken; others complete but do nothing
    assign addr_ok = hsel & htrans[`ETCS_HTRANS_ACT] & hready & (hsize == `ETCS_HSIZE_WORD);
    assign wbyte = hwdata[7:0];

    // reads insert one wait so a write just before is always seen
    assign hreadyout = ~bus_st[1];
    assign hresp = `ETCS_HRESP_OKAY;

    // data-phase write strobes
    assign wr_ctrl = wr_act & (dp_addr == `ETCS_OFS_CTRL);
    assign wr_flags = wr_act & (dp_addr == `ETCS_OFS_FLAGS);
    assign wr_tca = wr_act & (dp_addr == `ETCS_OFS_TCA);
    assign wr_tcb = wr_act & (dp_addr == `ETCS_OFS_TCB);
    assign wr_count = wr_act & (dp_addr == `ETCS_OFS_COUNT);
    assign wr_range = wr_act & (dp_addr == `ETCS_OFS_RANGE);
    assign rd_flags = bus_st[1] & (dp_addr == `ETCS_OFS_FLAGS);

    // flags register as software sees it
    assign flags_view = {flag, `ETCS_RSV_VAL, out_sel};

    // address phase capture and read sequencing
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bus_st <= ST_IDLE;
            dp_addr <= 8'h00;
            wr_act <= 1'b0;
        end else begin
            bus_st <= next_bus_st;
            wr_act <= addr_ok & hwrite;
            if (addr_ok) begin
                dp_addr <= haddr[7:0];
            end
        end
    end

    // next bus state
    always @* begin
        case (bus_st)
            ST_IDLE: begin
                next_bus_st = (addr_ok & ~hwrite) ? ST_RDW : ST_IDLE;
            end
            ST_RDW: begin
                next_bus_st = ST_RDD;
            end
            ST_RDD: begin
                next_bus_st = (addr_ok & ~hwrite) ? ST_RDW : ST_IDLE;
            end
            default: begin
                next_bus_st = ST_IDLE;
            end
        endcase
    end

    // read mux; unmapped offsets read as zero
    always @* begin
        case (dp_addr)
            `ETCS_OFS_CTRL: next_rdata = timer_control_reg;
            `ETCS_OFS_FLAGS: next_rdata = flags_view;
            `ETCS_OFS_TCA: next_rdata = time_constant_a;
            `ETCS_OFS_TCB: next_rdata = time_constant_b;
            `ETCS_OFS_COUNT: next_rdata = count_value;
            `ETCS_OFS_RANGE: next_rdata = {7'h00, prescale_range};
            default: next_rdata = 8'h00;
        endcase
    end

    // read data loaded at the end of the wait cycle, held until next read
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
        end else if (bus_st[1]) begin
            hrdata <= {`ETCS_RD_PAD, next_rdata};
        end
    end

    // ****************************************
    // control and constant registers
    // ****************************************

    // standby puts everything but the shared range bit back to reset
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            timer_control_reg <= `ETCS_RST_CTRL;
            out_sel <= `ETCS_RST_OS;
            time_constant_a <= `ETCS_RST_TC;
            time_constant_b <= `ETCS_RST_TC;
            prescale_range <= `ETCS_RST_RANGE;
        end else if (standby_req) begin
            timer_control_reg <= `ETCS_RST_CTRL;
            out_sel <= `ETCS_RST_OS;
            time_constant_a <= `ETCS_RST_TC;
            time_constant_b <= `ETCS_RST_TC;
        end else begin
            // unused clear-select bits 4:3 are not kept and read zero
            if (wr_ctrl) begin
                timer_control_reg <= {wbyte[`ETCS_IE_MSB:`ETCS_IE_LSB], 2'h0,
                                      wbyte[`ETCS_CKS_MSB:`ETCS_CKS_LSB]};
            end
            if (wr_flags) begin
                out_sel <= wbyte[`ETCS_OS_B_MSB:`ETCS_OS_A_LSB];
            end
            if (wr_tca) begin
                time_constant_a <= wbyte;
            end
            if (wr_tcb) begin
                time_constant_b <= wbyte;
            end
            if (wr_range) begin
                prescale_range <= wbyte[0];
            end
        end
    end

    // ****************************************
    // count source selection
    // ****************************************

    wire [2:0] cks;
    wire ext_rise;
    wire ext_fall;
    wire tap_now;
    wire int_pulse;
    reg ext_pulse;
    reg [3:0] tap_idx;
    wire count_pulse;

    assign cks = timer_control_reg[`ETCS_CKS_MSB:`ETCS_CKS_LSB];

    // external input is cleaned up before it may count
    etcs_ext_edge u_ext_edge (
        .hclk(hclk),
        .hresetn(hresetn),
        .pin_in(external_count_input),
        .rise(ext_rise),
        .fall(ext_fall)
    );

    // free-running prescaler, taps give the internal rates
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            presc <= {PRESC_W{1'b0}};
        end else begin
            presc <= presc + {{(PRESC_W-1){1'b0}}, 1'b1};
        end
    end

    // tap choice per channel and range bit
    always @* begin
        case (cks[1:0])
            `ETCS_SUB_1: begin
                tap_idx = prescale_range ? `ETCS_TAP_DIV2 : `ETCS_TAP_DIV8;
            end
            `ETCS_SUB_2: begin
                if (!prescale_range) begin
                    tap_idx = `ETCS_TAP_DIV64;
                end else if (CHANNEL == 0) begin
                    tap_idx = `ETCS_TAP_DIV32;
                end else begin
                    tap_idx = `ETCS_TAP_DIV128;
                end
            end
            default: begin
                if (!prescale_range) begin
                    tap_idx = `ETCS_TAP_DIV1024;
                end else if (CHANNEL == 0) begin
                    tap_idx = `ETCS_TAP_DIV256;
                end else begin
                    tap_idx = `ETCS_TAP_DIV2048;
                end
            end
        endcase
    end

    // a tap swap from high to low looks like a falling edge and counts
    assign tap_now = presc[tap_idx];

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tap_q <= 1'b0;
        end else begin
            tap_q <= tap_now;
        end
    end

    // internal rates count on the falling edge of the tap
    assign int_pulse = ~cks[`ETCS_CKS_EXT] & (cks[1:0] != `ETCS_SUB_NONE)
                       & tap_q & ~tap_now;

    // external edge modes, range bit plays no part
    always @* begin
        case ({cks[`ETCS_CKS_EXT], cks[1:0]})
            {1'b1, `ETCS_SUB_1}: ext_pulse = ext_rise;
            {1'b1, `ETCS_SUB_2}: ext_pulse = ext_fall;
            {1'b1, `ETCS_SUB_3}: ext_pulse = ext_rise | ext_fall;
            default: ext_pulse = 1'b0;
        endcase
    end

    // a counter write in the same cycle wins over the increment
    assign count_pulse = (int_pulse | ext_pulse) & ~wr_count;

    // ****************************************
    // counter and compare events
    // ****************************************

    wire match_a;
    wire match_b;
    wire wrap_evt;
    wire [2:0] set_evt;
    wire [2:0] clr_req;
    wire [2:0] irq_vec;

    // eight-bit up counter, software accessible except while standby holds it at reset
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count_value <= `ETCS_RST_COUNT;
        end else if (standby_req) begin
            count_value <= `ETCS_RST_COUNT;
        end else if (wr_count) begin
            count_value <= wbyte;
        end else if (count_pulse) begin
            count_value <= count_value + 8'h01;
        end
    end

    // compare fires as the matching value is left; a constant write masks it
    assign match_a = count_pulse & ~wr_tca & (count_value == time_constant_a);
    assign match_b = count_pulse & ~wr_tcb & (count_value == time_constant_b);
    assign wrap_evt = count_pulse & (count_value == `ETCS_COUNT_MAX);

    assign set_evt = {match_b, match_a, wrap_evt};

    // ****************************************
    // status flags and request lines
    // ****************************************

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_flag
            // a zero write clears only a flag that was read as set
            assign clr_req[gi] = wr_flags & armed[gi] & ~wbyte[`ETCS_FLAG_LSB + gi];

            always @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    flag[gi] <= 1'b0;
                    armed[gi] <= 1'b0;
                end else if (standby_req) begin
                    flag[gi] <= 1'b0;
                    armed[gi] <= 1'b0;
                end else begin
                    // set beats clear so no event is lost; ones are ignored
                    flag[gi] <= set_evt[gi] | (flag[gi] & ~clr_req[gi]);
                    if (rd_flags) begin
                        armed[gi] <= flag[gi];
                    end else if (clr_req[gi] & ~set_evt[gi]) begin
                        armed[gi] <= 1'b0;
                    end
                end
            end

            // request line follows flag and its enable
            assign irq_vec[gi] = flag[gi] & timer_control_reg[`ETCS_IE_LSB + gi];
        end
    endgenerate

    assign irq_wrap = irq_vec[`ETCS_FLAG_WRAP];
    assign irq_compare_a = irq_vec[`ETCS_FLAG_A];
    assign irq_compare_b = irq_vec[`ETCS_FLAG_B];

    // ****************************************
    // timer output
    // ****************************************

    wire [1:0] act_a;
    wire [1:0] act_b;
    reg next_level;

    assign act_a = match_a ? out_sel[`ETCS_OS_A_MSB:`ETCS_OS_A_LSB] : `ETCS_OS_KEEP;
    assign act_b = match_b ? out_sel[`ETCS_OS_B_MSB:`ETCS_OS_B_LSB] : `ETCS_OS_KEEP;

    // when both fire, toggle outranks high which outranks low
    always @* begin
        if (act_a == `ETCS_OS_TOG || act_b == `ETCS_OS_TOG) begin
            next_level = ~out_level;
        end else if (act_a == `ETCS_OS_HIGH || act_b == `ETCS_OS_HIGH) begin
            next_level = 1'b1;
        end else if (act_a == `ETCS_OS_LOW || act_b == `ETCS_OS_LOW) begin
            next_level = 1'b0;
        end else begin
            next_level = out_level;
        end
    end

    // output level starts low and moves only on compare, or back to low on standby
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            out_level <= `ETCS_RST_LEVEL;
        end else if (standby_req) begin
            out_level <= `ETCS_RST_LEVEL;
        end else begin
            out_level <= next_level;
        end
    end

    // with every select bit clear the output function is off and the pin low
    assign timer_output_en = |out_sel;
    assign timer_output_pin = out_level & timer_output_en;

endmodule // etcs_channel

`default_nettype wire

// [hw/etcs_ext_edge.v]
// synchroniser and edge detector for the external count input
`default_nettype none

module etcs_ext_edge (
    // system
    input wire hclk,
    input wire hresetn,
    // raw pin
    input wire pin_in,
    // one-cycle edge pulses
    output wire rise,
    output wire fall
);

    reg sync_a;
    reg sync_b;
    reg sync_c;

    // two flops tame metastability, the third holds the previous level
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync_a <= 1'b0;
            sync_b <= 1'b0;
            sync_c <= 1'b0;
        end else begin
            sync_a <= pin_in;
            sync_b <= sync_a;
            sync_c <= sync_b;
        end
    end

    // edges seen only on settled samples, so a glitch never counts twice
    assign rise = sync_b & ~sync_c;
    assign fall = ~sync_b & sync_c;

endmodule // etcs_ext_edge

`default_nettype wire

// [hw/etcs_map.vh]
// register map, field positions, reset values and codes of the timer channel
`ifndef ETCS_MAP_VH
`define ETCS_MAP_VH

// register byte offsets (one aligned word each)
`define ETCS_OFS_CTRL 8'h00
`define ETCS_OFS_FLAGS 8'h04
`define ETCS_OFS_TCA 8'h08
`define ETCS_OFS_TCB 8'h0C
`define ETCS_OFS_COUNT 8'h10
`define ETCS_OFS_RANGE 8'h14

// reset values
`define ETCS_RST_CTRL 8'h00
`define ETCS_RST_FLAGS 3'h0
`define ETCS_RST_OS 4'h0
`define ETCS_RST_TC 8'hFF
`define ETCS_RST_COUNT 8'h00
`define ETCS_RST_RANGE 1'b0
`define ETCS_RST_LEVEL 1'b0
`define ETCS_COUNT_MAX 8'hFF

// control register fields
`define ETCS_IE_MSB 7
`define ETCS_IE_LSB 5
`define ETCS_CKS_MSB 2
`define ETCS_CKS_LSB 0
`define ETCS_CKS_EXT 2

// flags register fields
`define ETCS_FLAG_MSB 7
`define ETCS_FLAG_LSB 5
`define ETCS_RSV_VAL 1'b1
`define ETCS_OS_B_MSB 3
`define ETCS_OS_B_LSB 2
`define ETCS_OS_A_MSB 1
`define ETCS_OS_A_LSB 0
`define ETCS_FLAG_WRAP 0
`define ETCS_FLAG_A 1
`define ETCS_FLAG_B 2

// clock select low-two-bit codes
`define ETCS_SUB_NONE 2'h0
`define ETCS_SUB_1 2'h1
`define ETCS_SUB_2 2'h2
`define ETCS_SUB_3 2'h3

// output select actions
`define ETCS_OS_KEEP 2'h0
`define ETCS_OS_LOW 2'h1
`define ETCS_OS_HIGH 2'h2
`define ETCS_OS_TOG 2'h3

// prescaler tap indices: tap k falls at rate /2^(k+1)
`define ETCS_TAP_DIV2 4'h0
`define ETCS_TAP_DIV8 4'h2
`define ETCS_TAP_DIV32 4'h4
`define ETCS_TAP_DIV64 4'h5
`define ETCS_TAP_DIV128 4'h6
`define ETCS_TAP_DIV256 4'h7
`define ETCS_TAP_DIV1024 4'h9
`define ETCS_TAP_DIV2048 4'hA

// bus encodings
`define ETCS_HSIZE_WORD 3'h2
`define ETCS_HTRANS_ACT 1
`define ETCS_HRESP_OKAY 1'b0
`define ETCS_RD_PAD 24'h000000

`endif

// [sim/etcs_channel_asserts.sv]
// concurrent checks on the ports of the timer channel
`default_nettype none

module etcs_channel_chk (
    // system
    input wire logic hclk,
    input wire logic hresetn,
    // bus
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic [31:0] hrdata,
    // pins
    input wire logic standby_req,
    input wire logic timer_output_pin,
    input wire logic timer_output_en,
    input wire logic irq_compare_a,
    input wire logic irq_compare_b,
    input wire logic irq_wrap
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // ***********
    // helper logic
    // ***********
    logic wr_dp;
    wire logic acc = hsel && htrans[1] && hready && (hsize == 3'h2);

    // marks the data phase of a write, when registers take new values
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_dp <= 1'b0;
        end else begin
            wr_dp <= acc && hwrite;
        end
    end

    sequence s_rd_req;
        acc && !hwrite;
    endsequence
    sequence s_rd_answer;
        !hreadyout ##1 hreadyout;
    endsequence

    property p_rd_wait;
        s_rd_req |=> s_rd_answer;
    endproperty
    a_rd_wait: assert property (p_rd_wait) else $error("read wait not one cycle");
    property p_wr_zero;
        acc && hwrite |=> hreadyout;
    endproperty
    a_wr_zero: assert property (p_wr_zero) else $error("write was stalled");
    property p_rsv;
        s_rd_req and haddr[7:0] == 8'h04 |-> ##2 hrdata[4];
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bit read low");
    property p_rd_hi;
        hrdata[31:8] == 24'h000000;
    endproperty
    a_rd_hi: assert property (p_rd_hi) else $error("upper read bits not zero");
    property p_rd_hold;
        hreadyout && $past(hreadyout) |-> $stable(hrdata);
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
    // enable must follow the select bits that the same read returns
    property p_pin_gate;
        s_rd_req and haddr[7:0] == 8'h04 |-> ##2 timer_output_en == (hrdata[3:0] != 4'h0);
    endproperty
    a_pin_gate: assert property (p_pin_gate) else $error("enable wrong for select");
    property p_en_src;
        $changed(timer_output_en) |-> $past(wr_dp) || $past(standby_req);
    endproperty
    a_en_src: assert property (p_en_src) else $error("enable moved without cause");
    property p_stby;
        standby_req [*2] |=> !timer_output_en && !irq_compare_a && !irq_compare_b && !irq_wrap;
    endproperty
    a_stby: assert property (p_stby) else $error("standby left state");
endmodule // etcs_channel_chk

bind etcs_channel etcs_channel_chk i_chk (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hready), .hreadyout(hreadyout),
    .hrdata(hrdata), .standby_req(standby_req), .timer_output_pin(timer_output_pin),
    .timer_output_en(timer_output_en), .irq_compare_a(irq_compare_a),
    .irq_compare_b(irq_compare_b), .irq_wrap(irq_wrap)
);

`default_nettype wire

// [sim/etcs_ext_src.sv]
// behavioural source driving the external count input of the timer channel
`default_nettype none

module etcs_ext_src (
    // system
    input wire logic hclk,
    // count pin
    output logic external_count_input
);
    timeunit 1ns;
    timeprecision 1ns;

    // ************
    // pulse source
    // ************
    // the line stands low between bursts, like a gated clock
    initial begin
        external_count_input = 1'b0;
    end

    // four cycles high, four low: wider than the synchroniser needs
    task automatic burst(input int n);
        repeat (n) begin
            @(posedge hclk);
            external_count_input <= 1'b1;
            repeat (4) @(posedge hclk);
            external_count_input <= 1'b0;
            repeat (3) @(posedge hclk);
        end
    endtask
endmodule // etcs_ext_src

`default_nettype wire

// [sim/test_eight_bit_timer_clock_and_compare_status.sv]
// self-checking bench of timer channel 0, and of the channel 1 prescaler rates, over their shared register bus
`default_nettype none
`define CHK(nm, exp, got) begin checked++; if ((got) !== (exp)) begin n_errors++; \
    $display("MISMATCH %s exp=%0h got=%0h", nm, exp, got); end end

module test_eight_bit_timer_clock_and_compare_status;
    timeunit 1ns;
    timeprecision 1ns;
    logic hclk, hresetn, hsel, hwrite, standby_req;
    logic [31:0] haddr, hwdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    wire logic hreadyout, hresp, pin, en, irq_a, irq_b, irq_w, ext;
    wire logic [31:0] hrdata, hrdata1;
    int n_errors = 0;
    int checked = 0;
    int cycles = 0;

    etcs_channel #(.CHANNEL(0), .PRESC_W(11)) i_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .standby_req(standby_req),
        .external_count_input(ext), .timer_output_pin(pin), .timer_output_en(en),
        .irq_compare_a(irq_a), .irq_compare_b(irq_b), .irq_wrap(irq_w)
    );
    // second channel shares the bus; its read data is looked at after reads of the first
    etcs_channel #(.CHANNEL(1), .PRESC_W(11)) i_dut_ch1 (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(), .hresp(), .hrdata(hrdata1), .standby_req(standby_req),
        .external_count_input(ext), .timer_output_pin(), .timer_output_en(),
        .irq_compare_a(), .irq_compare_b(), .irq_wrap()
    );
    etcs_ext_src i_src (.hclk(hclk), .external_count_input(ext));

    always #25 hclk = ~hclk;

    // *************
    // bus and tasks
    // *************
    // hold each phase until hready is sampled high; no cycle count assumed
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                        output logic [7:0] q);
        hsel <= 1'b1; htrans <= 2'h2; hwrite <= w; haddr <= {24'h000000, a};
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'h0; hwdata <= {24'h000000, d};
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        q = hrdata[7:0];
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        xfer(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] q);
        xfer(1'b0, a, 8'h00, q);
    endtask

    task automatic t_reset();
        logic [7:0] q;
        repeat (40) @(posedge hclk);
        rd(8'h00, q); `CHK("ctrl", 8'h00, q)
        rd(8'h04, q); `CHK("flags", 8'h10, q)
        rd(8'h08, q); `CHK("const_a", 8'hFF, q)
        rd(8'h0C, q); `CHK("const_b", 8'hFF, q)
        rd(8'h10, q); `CHK("count", 8'h00, q)
        rd(8'h14, q); `CHK("range", 8'h00, q)
        `CHK("pin", 1'b0, pin)
        `CHK("hresp", 1'b0, hresp)
        wr(8'h20, 8'h5A); rd(8'h20, q); `CHK("unmapped", 8'h00, q)
        wr(8'h04, 8'hE0); rd(8'h04, q); `CHK("flags_w1", 8'h10, q)
        $display("t_reset done");
    endtask

    // a window of sixteen periods, slack for the stop write and a switch count
    task automatic t_rate();
        int divs [6] = '{8, 64, 1024, 2, 32, 256};
        int divs1 [6] = '{8, 64, 1024, 2, 128, 2048};
        int n1;
        logic [7:0] q;
        for (int i = 0; i < 6; i++) begin
            wr(8'h14, (i < 3) ? 8'h00 : 8'h01);
            wr(8'h10, 8'h00);
            wr(8'h00, 8'h01 + 8'(i % 3));
            repeat (16 * divs[i]) @(posedge hclk);
            wr(8'h00, 8'h00);
            rd(8'h10, q);
            `CHK("rate", 1'b1, q >= 8'h0F && q <= 8'h12)
            n1 = 16 * divs[i] / divs1[i];
            `CHK("rate1", 1'b1, hrdata1[7:0] >= 8'(n1 - 1) && hrdata1[7:0] <= 8'(n1 + 2))
        end
        wr(8'h00, 8'h04); wr(8'h10, 8'h00);
        repeat (64) @(posedge hclk);
        rd(8'h10, q); `CHK("stop", 8'h00, q)
        $display("t_rate done");
    endtask

    task automatic t_ext();
        logic [7:0] q;
        for (int m = 1; m < 4; m++) begin
            wr(8'h00, 8'h04 + 8'(m));
            wr(8'h10, 8'h00);
            i_src.burst(5);
            repeat (6) @(posedge hclk);
            rd(8'h10, q); `CHK("ext", (m == 3) ? 8'h0A : 8'h05, q)
        end
        $display("t_ext done");
    endtask

    // both constants equal: every pair of output actions coincides
    task automatic t_compare();
        logic [7:0] q;
        logic p, ex;
        logic [1:0] a, b;
        wr(8'h08, 8'h02); wr(8'h0C, 8'h02);
        for (int k = 0; k < 16; k++) begin
            a = 2'(k); b = 2'(k >> 2);
            wr(8'h00, (k % 2) ? 8'h87 : 8'h47);
            wr(8'h10, 8'h02);
            rd(8'h04, q); wr(8'h04, {4'h0, b, a});
            rd(8'h04, q); `CHK("flags_clr", {4'h1, b, a}, q)
            p = pin;
            i_src.burst(1);
            repeat (6) @(posedge hclk);
            ex = (a == 2'h3 || b == 2'h3) ? !p : (a == 2'h2 || b == 2'h2) ? 1'b1 :
                 (a == 2'h1 || b == 2'h1) ? 1'b0 : p;
            `CHK("pin", ex, pin)
            `CHK("en", k != 0, en)
            `CHK("irq_ab", (k % 2) ? 2'h2 : 2'h1, {irq_b, irq_a})
            rd(8'h04, q); `CHK("flags_set", {4'hD, b, a}, q)
        end
        // zero write lands on the edge where the compares set the flags again
        wr(8'h10, 8'h02);
        fork
            i_src.burst(1);
            begin
                repeat (2) @(posedge hclk);
                wr(8'h04, 8'h0F);
            end
        join
        repeat (6) @(posedge hclk);
        rd(8'h04, q); `CHK("set_wins", 8'hDF, q)
        $display("t_compare done");
    endtask

    task automatic t_wrap();
        logic [7:0] q;
        wr(8'h08, 8'h80); wr(8'h0C, 8'h80); wr(8'h00, 8'hE5); wr(8'h10, 8'hFF);
        rd(8'h04, q); wr(8'h04, 8'h00);
        i_src.burst(1);
        repeat (6) @(posedge hclk);
        `CHK("irq_wrap", 1'b1, irq_w)
        `CHK("irq_a", 1'b0, irq_a)
        `CHK("irq_b", 1'b0, irq_b)
        wr(8'h04, 8'h00); rd(8'h04, q); `CHK("unarmed", 8'h30, q)
        rd(8'h10, q); `CHK("wrapped", 8'h00, q)
        wr(8'h00, 8'h05); repeat (2) @(posedge hclk); `CHK("irq_off", 1'b0, irq_w)
        wr(8'h00, 8'hE5); repeat (2) @(posedge hclk); `CHK("irq_on", 1'b1, irq_w)
        rd(8'h04, q); wr(8'h04, 8'h00);
        rd(8'h04, q); `CHK("armed", 8'h10, q)
        repeat (2) @(posedge hclk); `CHK("irq_clr", 1'b0, irq_w)
        $display("t_wrap done");
    endtask

    task automatic t_standby();
        logic [7:0] q;
        wr(8'h04, 8'h0F); wr(8'h14, 8'h01); wr(8'h10, 8'h33); wr(8'h08, 8'h44);
        standby_req <= 1'b1;
        repeat (3) @(posedge hclk);
        standby_req <= 1'b0;
        @(posedge hclk);
        rd(8'h04, q); `CHK("sb_flags", 8'h10, q)
        rd(8'h00, q); `CHK("sb_ctrl", 8'h00, q)
        rd(8'h10, q); `CHK("sb_count", 8'h00, q)
        rd(8'h08, q); `CHK("sb_const", 8'hFF, q)
        rd(8'h14, q); `CHK("sb_range", 8'h01, q)
        `CHK("sb_en", 1'b0, en)
        $display("t_standby done");
    endtask

    task automatic wrap_up();
        $display("checked %0d n_errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // hang guard well above the longest expected run
    always @(posedge hclk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            n_errors++;
            wrap_up();
        end
    end

    initial begin
        hclk = 1'b0; hresetn = 1'b0; hsel = 1'b0; haddr = 32'h00000000; htrans = 2'h0;
        hwrite = 1'b0; hsize = 3'h2; hwdata = 32'h00000000; standby_req = 1'b0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_reset();
        t_rate();
        t_ext();
        t_compare();
        t_wrap();
        t_standby();
        wrap_up();
    end
endmodule // test_eight_bit_timer_clock_and_compare_status

`default_nettype wire
